// file: logic/setq_top.sv
// Purpose: event capture, priority, queue, playback launch
// Assumes: inputs synchronous to CLK
// Notes:   APB registers, one aligned word each
//
// Summary of operation
// R01: five traps, seventeen limits, 128 software codes
// R02: fixed priority cpu, traps, software, voltages, rest
// R03: software speech only after loaded timeout expires
// R04: host loads timeout, then writes event code
// R05: host rewriting timeout cancels pending software speech
// R06: eight-entry queue served in arrival order
// R07: queue cleared after playback serviced it
// R08: vector code handed to playback engine
// R09: cpu vector 1, traps vectors 2 to 6
// R10: limit vectors 40h to 50h
// R11: software vectors 80h-FFh, never 0 or 32h
// R12: limit crossing sets status bit, unmasked interrupts
// R13: 8-bit sample codes drive speaker dac
// R14: flash address spans 16 megabits
// R15: traps rising edge by default, polarity selectable
// R16: strap sampled at reset, low enables speech
// R17: one address bit per pulse falling edge
// R18: full queue holds new events pending
// R19: every source latched pending until queued
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module setq_top
  import setq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter int unsigned DEPTH       = QUEUE_DEPTH
)
(
  input  wire logic                 CLK,
  input  wire logic                 RST_B,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 CPU_PRESENCE_IN_N,
  input  wire logic [N_TRAP-1:0]    EVENT_TRAP_IN,
  input  wire logic [N_LIMIT-1:0]   LIMIT_EVENT_IN,
  input  wire logic                 SPEECH_SEL_STRAP,
  output logic                      FLASH_ADDR_PULSE,
  output logic                      FLASH_CLK,
  output logic                      FLASH_DATA_O,
  output logic                      FLASH_DATA_OE_N,
  input  wire logic                 FLASH_DATA_I,
  input  wire logic                 FLASH_EOP,
  output logic [SAMPLE_W-1:0]       SPEAKER_DAC_OUT,
  output logic                      MGMT_INTERRUPT_N_O,
  output logic                      MGMT_INTERRUPT_N_OE_N,
  output logic                      IRQ_OUT
);
  import setq_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  // bus decode
  logic                 setup;
  logic                 wr_en;
  logic                 hit;
  logic [31:0]          rd_mux;

  // control and status state
  logic [N_TRAP-1:0]    trap_pol_q;
  logic [N_LIMIT-1:0]   int_mask_q;
  logic [N_LIMIT-1:0]   int_stat_q;
  logic [N_LIMIT-1:0]   int_w1c;
  logic                 flush;
  logic                 strap_done_q;
  logic                 speech_en_q;

  // software trigger timer
  logic [7:0]           timeout_q;
  logic                 loaded_q;
  logic                 armed_q;
  logic [6:0]           sw_code_q;
  logic [7:0]           to_cnt_q;
  logic [TW-1:0]        tick_cnt_q;
  logic                 tick;
  logic                 sw_expire;

  // event capture
  logic                 cpu_prev_q;
  logic [N_TRAP-1:0]    trap_prev_q;
  logic [N_TRAP-1:0]    trap_lvl;
  logic [N_LIMIT-1:0]   lim_prev_q;
  logic [N_LIMIT-1:0]   lim_ev;
  logic [N_SRC-1:0]     src_ev;
  logic [N_SRC-1:0]     pend_q;
  logic [N_SRC-1:0]     grant;
  logic                 grant_any;
  logic [7:0]           grant_vec;

  // queue
  logic [7:0]           vec_mem [DEPTH];
  logic [PW-1:0]        wr_ptr_q;
  logic [PW-1:0]        rd_ptr_q;
  logic [CW-1:0]        count_q;
  logic                 push;
  logic                 pop;
  logic                 q_full;

  // playback
  logic                 start_q;
  logic [7:0]           play_vec_q;
  logic                 pl_busy;
  logic                 pl_done;

  assign setup = PSEL & ~PENABLE & ~PREADY;
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

  always_comb
  begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (PADDR)
      ADDR_CTRL:     rd_mux[CTRL_POL_LSB +: N_TRAP] = trap_pol_q;
      ADDR_INT_MASK: rd_mux[N_LIMIT-1:0] = int_mask_q;
      ADDR_INT_STAT: rd_mux[N_LIMIT-1:0] = int_stat_q;
      ADDR_STATUS:
      begin
        rd_mux[STAT_CNT_LSB +: CW] = count_q;
        rd_mux[STAT_BUSY]          = pl_busy;
        rd_mux[STAT_SPEECH]        = speech_en_q;
        rd_mux[STAT_ARMED]         = armed_q;
        rd_mux[STAT_LOADED]        = loaded_q;
      end
      ADDR_TIMEOUT:  rd_mux[7:0] = timeout_q;
      ADDR_SW_TRIG:
      begin
        rd_mux[7:0]       = VEC_SW_BASE | {1'b0, sw_code_q};
        rd_mux[SWT_ARMED] = armed_q;
      end
      default:       hit = 1'b0;
    endcase
  end

  // ready one cycle after setup, no wait states
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= setup;
      PSLVERR <= setup & ~hit;
      if (setup && !PWRITE)
        PRDATA <= rd_mux;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      trap_pol_q <= TRAP_POL_RST;
      int_mask_q <= INT_MASK_RST;
    end
    else if (wr_en && PADDR == ADDR_CTRL)
      trap_pol_q <= PWDATA[CTRL_POL_LSB +: N_TRAP]; // [R15]
    else if (wr_en && PADDR == ADDR_INT_MASK)
      int_mask_q <= PWDATA[N_LIMIT-1:0];
  end

  assign flush   = wr_en && PADDR == ADDR_CTRL && PWDATA[CTRL_FLUSH];
  assign int_w1c = (wr_en && PADDR == ADDR_INT_STAT) ?
                   PWDATA[N_LIMIT-1:0] : '0;

  // set wins over clear
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      int_stat_q <= '0;
    else
      int_stat_q <= (int_stat_q & ~int_w1c) | lim_ev; // [R12]
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      IRQ_OUT               <= 1'b0;
      MGMT_INTERRUPT_N_O    <= 1'b0;
      MGMT_INTERRUPT_N_OE_N <= 1'b1;
    end
    else
    begin
      // open drain: only ever pulls low
      IRQ_OUT               <= |(int_stat_q & ~int_mask_q); // [R12]
      MGMT_INTERRUPT_N_OE_N <= ~|(int_stat_q & ~int_mask_q); // [R12]
    end
  end

  // strap caught at first edge after reset
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      strap_done_q <= 1'b0;
      speech_en_q  <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      speech_en_q  <= ~SPEECH_SEL_STRAP; // [R16]
    end
  end

  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      tick_cnt_q <= '0;
    else if (tick || !armed_q)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + TW'(1);
  end

  assign sw_expire = armed_q & tick & (to_cnt_q == 8'h00);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      timeout_q <= TIMEOUT_RST;
      loaded_q  <= 1'b0;
      armed_q   <= 1'b0;
      sw_code_q <= 7'h00;
      to_cnt_q  <= 8'h00;
    end
    else if (wr_en && PADDR == ADDR_TIMEOUT)
    begin
      // refresh drops the pending checkpoint
      timeout_q <= PWDATA[7:0]; // [R04]
      loaded_q  <= 1'b1;
      armed_q   <= 1'b0; // [R05]
    end
    else if (wr_en && PADDR == ADDR_SW_TRIG && loaded_q)
    begin
      sw_code_q <= PWDATA[6:0]; // [R04]
      to_cnt_q  <= timeout_q;
      armed_q   <= 1'b1; // [R03]
    end
    else if (armed_q && tick)
    begin
      if (to_cnt_q == 8'h00)
        armed_q <= 1'b0; // [R03]
      else
        to_cnt_q <= to_cnt_q - 8'h01;
    end
  end

  assign trap_lvl = EVENT_TRAP_IN ^ trap_pol_q;
  assign lim_ev   = LIMIT_EVENT_IN & ~lim_prev_q;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cpu_prev_q  <= 1'b0;
      trap_prev_q <= '0;
      lim_prev_q  <= '0;
    end
    else
    begin
      cpu_prev_q  <= CPU_PRESENCE_IN_N;
      trap_prev_q <= trap_lvl;
      lim_prev_q  <= LIMIT_EVENT_IN;
    end
  end

  always_comb
  begin
    src_ev                           = '0;
    src_ev[SRC_CPU]                  = CPU_PRESENCE_IN_N & ~cpu_prev_q;
    src_ev[SRC_TRAP0 +: N_TRAP]      = trap_lvl & ~trap_prev_q; // [R15]
    src_ev[SRC_SW]                   = sw_expire; // [R03]
    src_ev[SRC_LIM0 +: N_LIMIT]      = lim_ev; // [R01]
  end

  // lowest index wins; losers stay latched
  always_comb
  begin
    grant     = '0;
    grant_any = 1'b0;
    grant_vec = 8'h00;
    if (!q_full && !flush) // [R18]
    begin
      for (int i = 0; i < N_SRC; i++)
      begin
        if (pend_q[i] && !grant_any) // [R02]
        begin
          grant[i]  = 1'b1;
          grant_any = 1'b1;
          if (i == SRC_CPU)
            grant_vec = VEC_CPU; // [R09]
          else if (i < SRC_SW)
            grant_vec = VEC_TRAP0 + 8'(i - SRC_TRAP0); // [R09]
          else if (i == SRC_SW)
            grant_vec = VEC_SW_BASE | {1'b0, sw_code_q}; // [R11]
          else
            grant_vec = VEC_LIM0 + 8'(i - SRC_LIM0); // [R10]
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      pend_q <= '0;
    else
      pend_q <= (pend_q & ~grant) | src_ev; // [R19]
  end

  assign q_full = (count_q == CW'(DEPTH));
  assign push   = grant_any;
  assign pop    = start_q;

  always_ff @(posedge CLK)
  begin
    if (push)
      vec_mem[wr_ptr_q] <= grant_vec; // [R06]
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else if (flush || (pl_done && count_q == '0 && !push))
    begin
      // serviced queue emptied
      wr_ptr_q <= '0; // [R07]
      rd_ptr_q <= '0; // [R07]
      count_q  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + PW'(1);
      if (pop)
        rd_ptr_q <= rd_ptr_q + PW'(1); // [R06]
      if (push && !pop)
        count_q <= count_q + CW'(1);
      else if (pop && !push)
        count_q <= count_q - CW'(1);
    end
  end

  // busy follows start one edge later
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      start_q    <= 1'b0;
      play_vec_q <= 8'h00;
    end
    else
    begin
      start_q <= 1'b0;
      if (speech_en_q && !pl_busy && !start_q && !flush &&
          count_q != '0)
      begin
        start_q    <= 1'b1;
        play_vec_q <= vec_mem[rd_ptr_q]; // [R08]
      end
    end
  end

  setq_player u_player (
    .clk        (CLK),
    .rst_n      (RST_B),
    .en         (speech_en_q),
    .start      (start_q),
    .vector     (play_vec_q),
    .busy       (pl_busy),
    .done       (pl_done),
    .addr_pulse (FLASH_ADDR_PULSE),
    .flash_clk  (FLASH_CLK),
    .data_o     (FLASH_DATA_O),
    .data_oe_n  (FLASH_DATA_OE_N),
    .data_i     (FLASH_DATA_I),
    .eop_i      (FLASH_EOP),
    .dac        (SPEAKER_DAC_OUT)
  );

endmodule : setq_top

// file: logic/setq_pkg.sv
// Purpose: constants and types of the speech queue
// Assumes: 200 MHz clock, APB with 32-bit data
// Notes:   indexed register byte address is four times index
package setq_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned CLK_PERIOD_PS   = 5_000;
  localparam int unsigned TIMEOUT_UNIT_US = 1_000;
  localparam int unsigned TICK_CYCLES_DFLT =
    (CLK_HZ / 1_000_000) * TIMEOUT_UNIT_US;
  // serial half period, rounded up
  localparam int unsigned SER_HALF_NS     = 50;
  localparam int unsigned SER_HALF_CYC    =
    (SER_HALF_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // sources, index order is priority
  localparam int unsigned N_TRAP    = 5;
  localparam int unsigned N_LIMIT   = 17;
  localparam int unsigned N_SW      = 128;
  localparam int unsigned N_SRC     = 1 + N_TRAP + 1 + N_LIMIT;
  localparam int unsigned SRC_CPU   = 0;
  localparam int unsigned SRC_TRAP0 = 1;
  localparam int unsigned SRC_SW    = SRC_TRAP0 + N_TRAP;
  localparam int unsigned SRC_LIM0  = SRC_SW + 1;

  // event vectors
  localparam logic [7:0] VEC_CPU     = 8'h01;
  localparam logic [7:0] VEC_TRAP0   = 8'h02;
  localparam logic [7:0] VEC_LIM0    = 8'h40;
  localparam logic [7:0] VEC_SW_BASE = 8'h80;

  // queue
  localparam int unsigned QUEUE_DEPTH = 8;

  // register map, byte addresses
  localparam logic [7:0]  IDX_TIMEOUT   = 8'h08;
  localparam logic [7:0]  IDX_SW_TRIG   = 8'h09;
  localparam logic [11:0] ADDR_TIMEOUT  = {2'h0, IDX_TIMEOUT, 2'h0};
  localparam logic [11:0] ADDR_SW_TRIG  = {2'h0, IDX_SW_TRIG, 2'h0};
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_INT_MASK = 12'h004;
  localparam logic [11:0] ADDR_INT_STAT = 12'h008;
  localparam logic [11:0] ADDR_STATUS   = 12'h00C;

  // control fields
  localparam int unsigned CTRL_POL_LSB  = 0;
  localparam int unsigned CTRL_FLUSH    = 5;
  localparam logic [4:0]  TRAP_POL_RST  = 5'h00;
  // status fields
  localparam int unsigned STAT_CNT_LSB  = 0;
  localparam int unsigned STAT_BUSY     = 4;
  localparam int unsigned STAT_SPEECH   = 5;
  localparam int unsigned STAT_ARMED    = 6;
  localparam int unsigned STAT_LOADED   = 7;
  // software trigger read field
  localparam int unsigned SWT_ARMED     = 8;
  localparam logic [16:0] INT_MASK_RST  = 17'h00000;
  localparam logic [7:0]  TIMEOUT_RST   = 8'h00;

  // voice flash: 16 Mbit span, one slot per vector
  localparam int unsigned FLASH_AW  = 21;
  localparam int unsigned SLOT_BITS = 13;
  localparam int unsigned SAMPLE_W  = 8;

  typedef enum logic [4:0] {
    PL_IDLE    = 5'b00001,
    PL_ADDR_HI = 5'b00010,
    PL_ADDR_LO = 5'b00100,
    PL_READ_HI = 5'b01000,
    PL_READ_LO = 5'b10000
  } setq_pl_state_t;

endpackage : setq_pkg

// file: logic/setq_player.sv
// Purpose: speech playback from cascaded serial voice flash to the dac
// Assumes: flash latches data on falling strobe edges
// Notes:   start is honoured only while idle; done pulses one cycle
`timescale 1ns/1ps
module setq_player
  import setq_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                en,
  input  wire logic                start,
  input  wire logic [7:0]          vector,
  output logic                     busy,
  output logic                     done,
  output logic                     addr_pulse,
  output logic                     flash_clk,
  output logic                     data_o,
  output logic                     data_oe_n,
  input  wire logic                data_i,
  input  wire logic                eop_i,
  output logic [SAMPLE_W-1:0]      dac
);
  import setq_pkg::*;

  setq_pl_state_t         state_q;
  logic [7:0]             half_q;
  logic                   tick;
  logic [FLASH_AW-1:0]    addr_q;
  logic [4:0]             bit_q;
  logic [SAMPLE_W-1:0]    shift_q;

  assign tick = (half_q == 8'(SER_HALF_CYC - 1));
  assign busy = (state_q != PL_IDLE);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      half_q <= 8'h00;
    else if (state_q == PL_IDLE || tick)
      half_q <= 8'h00;
    else
      half_q <= half_q + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= PL_IDLE;
      addr_q     <= '0;
      bit_q      <= 5'h00;
      shift_q    <= '0;
      dac        <= '0;
      done       <= 1'b0;
      addr_pulse <= 1'b0;
      flash_clk  <= 1'b0;
      data_o     <= 1'b0;
      data_oe_n  <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      if (!en)
      begin
        state_q    <= PL_IDLE;
        addr_pulse <= 1'b0;
        flash_clk  <= 1'b0;
        data_oe_n  <= 1'b1;
      end
      else
      begin
        unique case (state_q)
          PL_IDLE:
          begin
            if (start)
            begin
              // one voice slot per vector
              addr_q    <= {vector, {SLOT_BITS{1'b0}}}; // [R14] [R08]
              bit_q     <= 5'(FLASH_AW - 1);
              data_o    <= vector[7];
              data_oe_n <= 1'b0;
              state_q   <= PL_ADDR_HI;
            end
          end
          PL_ADDR_HI:
          begin
            if (tick)
            begin
              addr_pulse <= 1'b1;
              state_q    <= PL_ADDR_LO;
            end
          end
          PL_ADDR_LO:
          begin
            if (tick)
            begin
              // falling edge shifts the bit in
              addr_pulse <= 1'b0; // [R17]
              if (bit_q == 5'h00)
              begin
                data_oe_n <= 1'b1;
                bit_q     <= 5'(SAMPLE_W - 1);
                state_q   <= PL_READ_HI;
              end
              else
              begin
                bit_q   <= bit_q - 5'h01;
                data_o  <= addr_q[bit_q - 5'h01]; // [R17]
                state_q <= PL_ADDR_HI;
              end
            end
          end
          PL_READ_HI:
          begin
            if (tick)
            begin
              flash_clk <= 1'b1;
              state_q   <= PL_READ_LO;
            end
          end
          PL_READ_LO:
          begin
            if (tick)
            begin
              flash_clk <= 1'b0;
              shift_q   <= {shift_q[SAMPLE_W-2:0], data_i};
              if (bit_q == 5'h00)
              begin
                // whole sample code at once
                dac   <= {shift_q[SAMPLE_W-2:0], data_i}; // [R13]
                bit_q <= 5'(SAMPLE_W - 1);
                if (eop_i)
                begin
                  done    <= 1'b1;
                  state_q <= PL_IDLE;
                end
                else
                  state_q <= PL_READ_HI;
              end
              else
              begin
                bit_q   <= bit_q - 5'h01;
                state_q <= PL_READ_HI;
              end
            end
          end
        endcase
      end
    end
  end

endmodule : setq_player

// file: verification/setq_chk.sv
// Purpose: port checks of the speech queue
// Assumes: one clock, RST_B async active low
// Notes:   bound to setq_top
`timescale 1ns/1ps
module setq_chk
  import setq_pkg::*;
(
  input logic       CLK,
  input logic       RST_B,
  input logic       PSEL,
  input logic       PENABLE,
  input logic       PREADY,
  input logic       PSLVERR,
  input logic       SPEECH_SEL_STRAP,
  input logic       FLASH_ADDR_PULSE,
  input logic       FLASH_CLK,
  input logic       FLASH_DATA_O,
  input logic       FLASH_DATA_OE_N,
  input logic [7:0] SPEAKER_DAC_OUT,
  input logic       MGMT_INTERRUPT_N_O,
  input logic       MGMT_INTERRUPT_N_OE_N,
  input logic       IRQ_OUT
);
  logic first_q;
  logic strap_off_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // strap judged at first edge
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      first_q     <= 1'h1;
      strap_off_q <= 1'h0;
    end
    else
    begin
      first_q <= 1'h0;
      if (first_q)
        strap_off_q <= SPEECH_SEL_STRAP;
    end

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence

  sequence s_pulse_start;
    $rose(FLASH_ADDR_PULSE);
  endsequence

  chk_ready_after_setup: assert property (s_setup |=> PREADY)
    else $error("no ready");
  chk_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  chk_err_in_access: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("stray error");
  chk_irq_pins_agree: assert property (
    !MGMT_INTERRUPT_N_O && (IRQ_OUT == !MGMT_INTERRUPT_N_OE_N))
    else $error("irq mismatch");
  chk_pulse_driven: assert property (
    FLASH_ADDR_PULSE |-> !FLASH_DATA_OE_N)
    else $error("pulse undriven");
  chk_addr_data_steady: assert property (
    FLASH_ADDR_PULSE && $past(FLASH_ADDR_PULSE) |-> $stable(FLASH_DATA_O))
    else $error("bit moved");
  chk_pulse_width: assert property (
    s_pulse_start |-> FLASH_ADDR_PULSE[*8])
    else $error("pulse short");
  chk_clk_in_read: assert property (
    $rose(FLASH_CLK) |-> FLASH_DATA_OE_N)
    else $error("early clock");
  chk_dac_in_read: assert property (
    !$stable(SPEAKER_DAC_OUT) |-> FLASH_DATA_OE_N && !FLASH_ADDR_PULSE)
    else $error("stray dac change");
  chk_strap_off: assert property (
    strap_off_q |-> FLASH_DATA_OE_N && !FLASH_ADDR_PULSE && !FLASH_CLK)
    else $error("pins active");
endmodule : setq_chk

bind setq_top setq_chk setq_chk_inst (.CLK, .RST_B, .PSEL, .PENABLE,
  .PREADY, .PSLVERR, .SPEECH_SEL_STRAP, .FLASH_ADDR_PULSE, .FLASH_CLK,
  .FLASH_DATA_O, .FLASH_DATA_OE_N, .SPEAKER_DAC_OUT, .MGMT_INTERRUPT_N_O,
  .MGMT_INTERRUPT_N_OE_N, .IRQ_OUT);

// file: verification/setq_flash_model.sv
// Purpose: cascaded serial voice flash
// Assumes: sample code is a pattern of vector and index
// Notes:   n_samp samples per voice
`timescale 1ns/1ps
module setq_flash_model (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       addr_pulse,
  input  logic       flash_clk,
  input  logic       data_o,
  input  logic       data_oe_n,
  input  logic [1:0] n_samp,
  output logic       data_i,
  output logic       eop,
  output logic [7:0] vec,
  output int         n_vec,
  output int         n_bits
);
  logic        ap_q;
  logic        fc_q;
  logic        bit_q;
  logic [19:0] addr_q;
  int          n_addr;
  logic [7:0]  smp;

  assign smp    = {vec[3:0], 4'(n_bits / 8)} ^ 8'h5A;
  // driven line reads back the inverse bit
  assign data_i = data_oe_n ? smp[3'(7 - n_bits % 8)] : ~data_o;
  assign eop    = (n_bits / 8 == int'(n_samp) - 1);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ap_q   <= 1'h0;
      fc_q   <= 1'h0;
      bit_q  <= 1'h0;
      addr_q <= 20'h00000;
      n_addr <= 0;
      n_vec  <= 0;
      n_bits <= 0;
      vec    <= 8'h00;
    end
    else
    begin
      ap_q <= addr_pulse;
      fc_q <= flash_clk;
      // bit may change with the falling edge
      if (addr_pulse)
        bit_q <= data_o;
      if (ap_q && !addr_pulse)
      begin
        addr_q <= {addr_q[18:0], bit_q};
        n_addr <= (n_addr == 20) ? 0 : n_addr + 1;
        n_bits <= 0;
        if (n_addr == 20)
        begin
          vec   <= addr_q[19:12];
          n_vec <= n_vec + 1;
        end
      end
      if (fc_q && !flash_clk)
        n_bits <= n_bits + 1;
    end
endmodule : setq_flash_model

// file: verification/test_speech_event_trigger_queue.sv
// Purpose: self-checking bench of the speech queue
// Assumes: tick of 8 cycles, flash model on the pins
// Notes:   fixed-seed shift register drives random cases
`timescale 1ns/1ps
module test_speech_event_trigger_queue;
  import setq_pkg::*;
  localparam int LIMIT = 40000;
  logic                CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0]         PADDR;
  logic [31:0]         PWDATA, PRDATA, r;
  logic                CPU_PRESENCE_IN_N, SPEECH_SEL_STRAP, FLASH_ADDR_PULSE;
  logic                FLASH_CLK, FLASH_DATA_O, FLASH_DATA_OE_N, FLASH_DATA_I;
  logic                FLASH_EOP, MGMT_INTERRUPT_N_O, MGMT_INTERRUPT_N_OE_N;
  logic                IRQ_OUT, e;
  logic [N_TRAP-1:0]   EVENT_TRAP_IN;
  logic [N_LIMIT-1:0]  LIMIT_EVENT_IN;
  logic [SAMPLE_W-1:0] SPEAKER_DAC_OUT;
  logic [7:0]          m_vec;
  logic [1:0]          ns;
  logic [15:0]         rnd;
  int                  m_nvec, m_bits, cyc, n_errors, checks;
  logic [7:0]          pv [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                  8'h40, 8'h41, 8'h50};
  logic [11:0]         ra [5] = '{ADDR_CTRL, ADDR_INT_MASK, ADDR_TIMEOUT,
                                  ADDR_STATUS, 12'h010};
  logic [31:0]         rv [5] = '{32'h0, 32'h0, 32'h0, 32'h20, 32'h0};

  setq_top #(.TICK_CYCLES(8), .DEPTH(8)) setq_top_inst (.CLK, .RST_B, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .CPU_PRESENCE_IN_N, .EVENT_TRAP_IN, .LIMIT_EVENT_IN, .SPEECH_SEL_STRAP,
    .FLASH_ADDR_PULSE, .FLASH_CLK, .FLASH_DATA_O, .FLASH_DATA_OE_N,
    .FLASH_DATA_I, .FLASH_EOP, .SPEAKER_DAC_OUT, .MGMT_INTERRUPT_N_O,
    .MGMT_INTERRUPT_N_OE_N, .IRQ_OUT);
  setq_flash_model setq_flash_model_inst (.clk(CLK), .rst_n(RST_B),
    .addr_pulse(FLASH_ADDR_PULSE), .flash_clk(FLASH_CLK),
    .data_o(FLASH_DATA_O), .data_oe_n(FLASH_DATA_OE_N), .n_samp(ns),
    .data_i(FLASH_DATA_I), .eop(FLASH_EOP), .vec(m_vec), .n_vec(m_nvec),
    .n_bits(m_bits));

  initial
  begin
    CLK = 1'h0;
    forever #2.5 CLK = ~CLK;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic logic [7:0] exp_smp(input logic [7:0] v, input int k);
    return {v[3:0], 4'(k)} ^ 8'h5A;
  endfunction : exp_smp

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL   <= 1'h1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do @(posedge CLK); while (PREADY !== 1'h1);
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb

  task automatic reset(input logic strap);
    RST_B            <= 1'h0;
    SPEECH_SEL_STRAP <= strap;
    repeat (5) @(posedge CLK);
    RST_B <= 1'h1;
  endtask : reset

  // next voice slot, then its last sample
  task automatic play(input logic [7:0] v);
    int n0;
    n0 = m_nvec;
    while (m_nvec == n0) @(posedge CLK);
    check("vector", m_vec, v);
    while (m_bits < 8 * ns) @(posedge CLK);
    repeat (4) @(posedge CLK);
    check("dac", SPEAKER_DAC_OUT, exp_smp(v, ns - 1));
  endtask : play

  task automatic conclude;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    int          b;
    logic [31:0] mk;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {CPU_PRESENCE_IN_N, EVENT_TRAP_IN, LIMIT_EVENT_IN} = '0;
    RST_B = 1'h0;
    SPEECH_SEL_STRAP = 1'h1;
    ns = 2'h1;
    rnd = 16'h269C;
    reset(1'h1);
    LIMIT_EVENT_IN[5] <= 1'h1;
    repeat (20) @(posedge CLK);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check("strap off", r, 32'h01);
    LIMIT_EVENT_IN <= '0;
    reset(1'h0);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'h0, ra[i], 32'h0);
      check("reset", r, rv[i]);
      check("slverr", e, i == 4);
    end
    // cpu, all traps and limits 0, 1 and 16 at once
    CPU_PRESENCE_IN_N <= 1'h1;
    EVENT_TRAP_IN     <= 5'h1F;
    LIMIT_EVENT_IN    <= 17'h10003;
    repeat (12) @(posedge CLK);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check("count", r[3:0], 4'h8);
    foreach (pv[i]) play(pv[i]);
    {EVENT_TRAP_IN, LIMIT_EVENT_IN} <= '0;
    repeat (30) @(posedge CLK);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check("cleared", r, 32'h20);
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      b = rnd % 17;
      ns = 2'(1 + rnd[9:8] % 3);
      mk = {15'h0, rnd, rnd[3]};
      apb(1'h1, ADDR_INT_STAT, 32'h1FFFF);
      apb(1'h1, ADDR_INT_MASK, mk);
      LIMIT_EVENT_IN[b] <= 1'h1;
      repeat (4) @(posedge CLK);
      check("irq", IRQ_OUT, !mk[b]);
      apb(1'h0, ADDR_INT_STAT, 32'h0);
      check("int stat", r, 32'h1 << b);
      play(8'(8'h40 + b));
      LIMIT_EVENT_IN <= '0;
    end
    ns = 2'h1;
    apb(1'h1, ADDR_SW_TRIG, 32'h05);
    apb(1'h0, ADDR_SW_TRIG, 32'h0);
    check("unloaded", r[8], 1'h0);
    apb(1'h1, ADDR_TIMEOUT, 32'h03);
    apb(1'h1, ADDR_SW_TRIG, 32'h32);
    apb(1'h0, ADDR_SW_TRIG, 32'h0);
    check("armed", r, 32'h1B2);
    repeat (14) @(posedge CLK);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check("withheld", r, 32'hE0);
    play(8'hB2);
    apb(1'h1, ADDR_TIMEOUT, 32'h00);
    apb(1'h1, ADDR_SW_TRIG, 32'h00);
    play(8'h80);
    apb(1'h1, ADDR_TIMEOUT, 32'h03);
    apb(1'h1, ADDR_SW_TRIG, 32'h10);
    apb(1'h1, ADDR_TIMEOUT, 32'h03);
    repeat (200) @(posedge CLK);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check("refresh", r, 32'hA0);
    conclude();
  end
endmodule : test_speech_event_trigger_queue
